/* File: adcrb_bank.sv */
// Pointer-addressed register bank of a 16-bit converter behind a serial slave front end.
// How it works
// - Result is 16-bit two's complement code.
// - Out-of-range inputs saturate, never wrap around.
// - Zero, plus and minus one LSB map exactly.
// - Four registers, selected by current pointer.
// - Pointer codes result, setup, low, high.
// - Result register is read-only, writes ignored.
// - Result is zero until first conversion.
// - Setup register resets to 8583h.
// - Setup fields at their documented bit positions.
// - Writing one when idle starts single conversion.
// - Start writes ignored while converting.
// - Start bit reads zero while busy.
// - Limit reads return zero and writes are ignored on comparator-less variant; limit outputs hold reset values.
// - Pointer is retained until rewritten.
// - Words travel upper byte first, lower second.
// - Mode bit zero runs continuous conversions.
`timescale 1ns/1ps
`include "adcrb_consts.svh"
module adcrb_bank #(
  parameter bit HAS_LIMITS = 1'b1  // Clear for the variant without a comparator.
) (
  input  wire logic                     i_clk,         // System clock, 100 MHz.
  input  wire logic                     i_reset_n,     // Synchronous active-low reset.
  input  wire adcrb_pkg::adcrb_access_s i_access,      // Decoded pointer and register writes.
  input  wire logic                     i_read_start,  // Pulse at the start of a read transfer.
  input  wire logic                     i_byte_next,   // Pulse when the upper byte was sent.
  input  wire logic [19:0]              i_sample,      // Raw signed sample from the modulator.
  output logic      [7:0]               o_read_byte,   // Byte to be shifted out next.
  output logic      [15:0]              o_setup,       // Setup word for the analog side.
  output logic      [15:0]              o_low_limit,   // Low comparator limit.
  output logic      [15:0]              o_high_limit,  // High comparator limit.
  output logic                          o_busy         // High while a conversion runs.
);
  localparam logic [15:0] CONV_CYCLES = 16'(`ADCRB_CONV_CYCLES);

  logic [15:0]            code;                   // Clipped code of the current sample.
  logic [1:0]             ptr_q, ptr_d;           // Register pointer.
  logic [15:0]            result_q, result_d;     // Result register.
  adcrb_pkg::adcrb_setup_s setup_q, setup_d;      // Setup register.
  logic [15:0]            low_q, low_d;           // Low limit register.
  logic [15:0]            high_q, high_d;         // High limit register.
  adcrb_pkg::adcrb_state_e state_q, state_d;      // Conversion engine state.
  logic [15:0]            cnt_q, cnt_d;           // Conversion timer.
  logic [15:0]            shadow_q, shadow_d;     // Word frozen for the running read.
  logic [7:0]             rbyte_q, rbyte_d;       // Outgoing byte register.

  // Selects the word a read returns; the start bit shows the live idle state.
  function automatic logic [15:0] read_word(input logic [1:0] p, input logic busy,
                                            input logic [15:0] res, input logic [15:0] stp,
                                            input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] w;
    w = 16'h0000;
    case (p)
      `ADCRB_PTR_RESULT:     w = res;
      `ADCRB_PTR_SETUP:      w = {~busy, stp[14:0]};
      `ADCRB_PTR_LOW_LIMIT:  w = HAS_LIMITS ? lo : 16'h0000;
      `ADCRB_PTR_HIGH_LIMIT: w = HAS_LIMITS ? hi : 16'h0000;
      default:               w = 16'h0000;
    endcase
    return w;
  endfunction

  // Saturating code conversion lives in its own leaf, so no sample can wrap past full scale.
  adcrb_clip u_clip (
    .i_sample (i_sample),
    .o_code   (code)
  );

  // Pointer, configuration and limit registers.
  always_comb begin
    ptr_d   = ptr_q;
    setup_d = setup_q;
    low_d   = low_q;
    high_d  = high_q;
    // Only the two low pointer bits are kept; the master keeps the rest zero.
    if (i_access.ptr_wr) begin
      ptr_d = i_access.ptr_byte[1:0];
    end
    // Writes land on the register the pointer names; the result word is not writable.
    if (i_access.reg_wr) begin
      case (ptr_d)
        `ADCRB_PTR_SETUP: begin
          setup_d = adcrb_pkg::adcrb_setup_s'(i_access.reg_data);
          // The start bit is not stored as written; it always reflects status.
          setup_d.status_and_start = 1'b1;
        end
        `ADCRB_PTR_LOW_LIMIT:  low_d  = HAS_LIMITS ? i_access.reg_data : low_q;
        `ADCRB_PTR_HIGH_LIMIT: high_d = HAS_LIMITS ? i_access.reg_data : high_q;
        default:               ;  // Result register ignores writes.
      endcase
    end
  end

  // Registers the configuration group.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ptr_q   <= `ADCRB_PTR_RESULT;
      setup_q <= adcrb_pkg::adcrb_setup_s'(`ADCRB_SETUP_RESET);
      low_q   <= `ADCRB_LOW_RESET;
      high_q  <= `ADCRB_HIGH_RESET;
    end else begin
      ptr_q   <= ptr_d;
      setup_q <= setup_d;
      low_q   <= low_d;
      high_q  <= high_d;
    end
  end

  // Conversion engine: a timer stands in for the analog conversion time.
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    case (state_q)
      adcrb_pkg::ADCRB_IDLE: begin
        // Continuous mode restarts at once; in single-shot mode a start write
        // is only honoured here, in power-down.
        if (!setup_q.single_shot) begin
          state_d = adcrb_pkg::ADCRB_BUSY;
          cnt_d   = CONV_CYCLES;
        end else if (i_access.reg_wr && ptr_d == `ADCRB_PTR_SETUP &&
                     i_access.reg_data[`ADCRB_BIT_START]) begin
          state_d = adcrb_pkg::ADCRB_BUSY;
          cnt_d   = CONV_CYCLES;
        end
      end
      adcrb_pkg::ADCRB_BUSY: begin
        // Start writes are not looked at while busy.
        if (cnt_q <= 16'h0001) begin
          // The whole word is loaded in one edge, the only writer of the result.
          result_d = code;
          state_d  = adcrb_pkg::ADCRB_IDLE;
          cnt_d    = 16'h0000;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        state_d = adcrb_pkg::ADCRB_IDLE;
        cnt_d   = 16'h0000;
      end
    endcase
  end

  // Registers the conversion group.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q  <= adcrb_pkg::ADCRB_IDLE;
      cnt_q    <= 16'h0000;
      result_q <= `ADCRB_RESULT_RESET;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
    end
  end

  // Read path: the word is frozen at the start of a read so that both bytes come
  // from one snapshot even if a conversion ends mid-transfer.
  always_comb begin
    shadow_d = shadow_q;
    rbyte_d  = rbyte_q;
    if (i_read_start) begin
      shadow_d = read_word(ptr_q, state_q == adcrb_pkg::ADCRB_BUSY, result_q,
                           setup_q, low_q, high_q);
      rbyte_d  = shadow_d[15:8];
    end else if (i_byte_next) begin
      rbyte_d = shadow_q[7:0];
    end
  end

  // Registers the read group.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      shadow_q <= 16'h0000;
      rbyte_q  <= 8'h00;
    end else begin
      shadow_q <= shadow_d;
      rbyte_q  <= rbyte_d;
    end
  end

  // Outputs come straight from flip-flops.
  always_comb begin
    o_read_byte  = rbyte_q;
    o_setup      = setup_q;
    o_low_limit  = low_q;
    o_high_limit = high_q;
    o_busy       = state_q[1];
  end
endmodule

/* File: adcrb_consts.svh */
// Constants for the converter register bank: offsets, field positions, reset values and timing.
`ifndef ADCRB_CONSTS_SVH
`define ADCRB_CONSTS_SVH
`define ADCRB_PTR_RESULT      2'h0
`define ADCRB_PTR_SETUP       2'h1
`define ADCRB_PTR_LOW_LIMIT   2'h2
`define ADCRB_PTR_HIGH_LIMIT  2'h3
`define ADCRB_RESULT_RESET    16'h0000
`define ADCRB_SETUP_RESET     16'h8583
`define ADCRB_LOW_RESET       16'h8000
`define ADCRB_HIGH_RESET      16'h7FFF
`define ADCRB_CODE_POS_MAX    16'h7FFF
`define ADCRB_CODE_NEG_MIN    16'h8000
`define ADCRB_BIT_START       15
`define ADCRB_BIT_MODE        8
`define ADCRB_CONV_TIME_NS    1000
`define ADCRB_CLK_PERIOD_NS   10
`define ADCRB_CONV_CYCLES     (`ADCRB_CONV_TIME_NS / `ADCRB_CLK_PERIOD_NS)
`endif

/* File: adcrb_pkg.sv */
// Types shared by the converter register bank files.
package adcrb_pkg;
  // Configuration word as stored in the setup register.
  typedef struct packed {
    logic       status_and_start;
    logic [2:0] input_select;
    logic [2:0] gain_range;
    logic       single_shot;
    logic [2:0] rate_select;
    logic       alert_window;
    logic       alert_polarity;
    logic       alert_latching;
    logic [1:0] alert_queue;
  } adcrb_setup_s;
  // One register access from the serial slave front end.
  typedef struct packed {
    logic        ptr_wr;
    logic [7:0]  ptr_byte;
    logic        reg_wr;
    logic [15:0] reg_data;
  } adcrb_access_s;
  // Conversion engine states.
  typedef enum logic [1:0] {
    ADCRB_IDLE = 2'b01,
    ADCRB_BUSY = 2'b10
  } adcrb_state_e;
endpackage

/* File: adcrb_clip.sv */
// Saturating converter that turns a wide signed sample into the 16-bit result code.
`timescale 1ns/1ps
`include "adcrb_consts.svh"
module adcrb_clip (
  input  wire logic [19:0] i_sample,  // Wide signed raw sample, one LSB equals one output code.
  output logic      [15:0] o_code     // Two's complement result code.
);
  // Clip at the full-scale codes instead of wrapping; in-range values pass unchanged, so
  // zero gives 0000h, one LSB gives 0001h and minus one LSB gives FFFFh.
  always_comb begin
    if ($signed(i_sample) > $signed({4'h0, `ADCRB_CODE_POS_MAX})) begin
      o_code = `ADCRB_CODE_POS_MAX;
    end else if ($signed(i_sample) < $signed({4'hF, `ADCRB_CODE_NEG_MIN})) begin
      o_code = `ADCRB_CODE_NEG_MIN;
    end else begin
      o_code = i_sample[15:0];
    end
  end
endmodule

/* File: adcrb_bank_chk.sv */
// Port-level property checker for the converter register bank.
`timescale 1ns/1ps
module adcrb_bank_chk (
  input wire logic                     i_clk,
  input wire logic                     i_reset_n,
  input wire adcrb_pkg::adcrb_access_s i_access,
  input wire logic                     o_busy,
  input wire logic [15:0]              o_setup,
  input wire logic [15:0]              o_low_limit,
  input wire logic [15:0]              o_high_limit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [1:0] sel;  // Pointer carried with the write.
  logic       wr;   // Pointer and data written together.
  logic [15:0] dat; // Data word of the write.
  assign sel = i_access.ptr_byte[1:0];
  assign wr  = i_access.ptr_wr && i_access.reg_wr;
  assign dat = i_access.reg_data;
  property p_rst; disable iff (1'h0) !i_reset_n |=> o_setup == 16'h8583 && !o_busy; endproperty
  property p_go; wr && sel == 2'h1 && dat[15] && dat[8] && !o_busy |=> o_busy; endproperty
  property p_nogo; wr && sel == 2'h1 && !dat[15] && dat[8] && o_setup[8] && !o_busy |=> !o_busy; endproperty
  property p_hold; $rose(o_busy) |-> o_busy[*8]; endproperty
  property p_cfg; wr && sel == 2'h1 |=> o_setup[14:0] == $past(dat[14:0]); endproperty
  property p_lo; wr && sel == 2'h2 |=> o_low_limit == $past(dat); endproperty
  property p_hi; wr && sel == 2'h3 |=> o_high_limit == $past(dat); endproperty
  property p_ro; wr && sel == 2'h0 |=> $stable(o_setup) && $stable(o_low_limit) && $stable(o_high_limit); endproperty
  property p_lim; !i_access.reg_wr |=> $stable(o_low_limit) && $stable(o_high_limit); endproperty
  a_rst: assert property (p_rst) else $error("setup or busy wrong after reset");
  a_go: assert property (p_go) else $error("start write did not launch");
  a_nogo: assert property (p_nogo) else $error("zero start bit launched");
  a_hold: assert property (p_hold) else $error("busy dropped early");
  a_cfg: assert property (p_cfg) else $error("setup fields not written");
  a_lo: assert property (p_lo) else $error("low limit not written");
  a_hi: assert property (p_hi) else $error("high limit not written");
  a_ro: assert property (p_ro) else $error("result write touched others");
  a_lim: assert property (p_lim) else $error("limit changed without write");
  c_go: cover property ($rose(o_busy));
  c_lo: cover property (wr && sel == 2'h2);
  c_ro: cover property (wr && sel == 2'h0);
  c_cont: cover property (wr && sel == 2'h1 && dat[15] && !dat[8]);
endmodule

/* File: adcrb_master.sv */
// Behavioural serial master issuing pointer writes, register writes and two-byte reads.
`timescale 1ns/1ps
module adcrb_master (
  input  wire logic               i_clk,
  input  wire logic [7:0]         i_read_byte,
  output adcrb_pkg::adcrb_access_s o_access,
  output logic                    o_read_start,
  output logic                    o_byte_next
);
  initial begin
    o_access = '0;
    o_read_start = 1'h0;
    o_byte_next = 1'h0;
  end
  // Every write carries the pointer byte, reserved bits held at zero.
  task automatic put(input logic [1:0] p, input logic w, input logic [15:0] d);
    @(posedge i_clk);
    o_access <= '{1'h1, {6'h00, p}, w, d};
    @(posedge i_clk);
    o_access <= '0;
  endtask
  // Upper byte arrives first, lower second, sampled once settled.
  task automatic get(output logic [15:0] v);
    @(posedge i_clk);
    o_read_start <= 1'h1;
    @(posedge i_clk);
    o_read_start <= 1'h0;
    o_byte_next <= 1'h1;
    #1;
    v[15:8] = i_read_byte;
    @(posedge i_clk);
    o_byte_next <= 1'h0;
    #1;
    v[7:0] = i_read_byte;
  endtask
endmodule

/* File: tb_adcrb_bank.sv */
// Self-checking bench for the converter register bank.
`timescale 1ns/1ps
`include "adcrb_consts.svh"
module tb_adcrb_bank;
  logic i_clk, i_reset_n, i_read_start, i_byte_next, o_busy;
  logic [19:0] i_sample;
  logic [7:0]  o_read_byte;
  logic [15:0] o_setup, o_low_limit, o_high_limit, v;
  adcrb_pkg::adcrb_access_s i_access;
  int bad_count = 0;
  int total_checks = 0;
  logic [19:0] smp [7] = '{20'h00000, 20'h00001, 20'hFFFFF, 20'h07FFF, 20'h08000, 20'hF8000, 20'hF7FFF};
  logic [15:0] exp [7] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000};
  adcrb_bank #(.HAS_LIMITS(1'h1)) u_adcrb_bank (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_access(i_access),
    .i_read_start(i_read_start), .i_byte_next(i_byte_next), .i_sample(i_sample), .o_read_byte(o_read_byte),
    .o_setup(o_setup), .o_low_limit(o_low_limit), .o_high_limit(o_high_limit), .o_busy(o_busy));
  adcrb_master u_adcrb_master (.i_clk(i_clk), .i_read_byte(o_read_byte), .o_access(i_access),
    .o_read_start(i_read_start), .o_byte_next(i_byte_next));
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Waits, bounded, for the conversion to end.
  task automatic idle;
    for (int i = 0; i < 200 && o_busy !== 1'h0; i++) @(posedge i_clk);
    #1;
    check("idle", {15'h0000, o_busy}, 16'h0000);
  endtask
  task automatic t_reset;
    u_adcrb_master.get(v);
    check("result", v, 16'h0000);
    u_adcrb_master.put(2'h1, 1'h0, 16'h0000);
    u_adcrb_master.get(v);
    check("setup", v, 16'h8583);
    check("limits", o_low_limit ^ o_high_limit, 16'hFFFF);
    check("low_reset", o_low_limit, `ADCRB_LOW_RESET);
    check("high_reset", o_high_limit, `ADCRB_HIGH_RESET);
  endtask
  // Each sample converts once; status reads busy, then the clipped code.
  task automatic t_clip;
    for (int k = 0; k < 7; k++) begin
      @(posedge i_clk);
      i_sample <= smp[k];
      u_adcrb_master.put(2'h1, 1'h1, 16'h8583);
      u_adcrb_master.get(v);
      check("status", {15'h0000, v[15]}, 16'h0000);
      idle();
      u_adcrb_master.put(2'h0, 1'h0, 16'h0000);
      u_adcrb_master.get(v);
      check("code", v, exp[k]);
      u_adcrb_master.get(v);
      check("again", v, exp[k]);
    end
  endtask
  // Start writes while busy are dropped, but other fields still land.
  task automatic t_busy;
    u_adcrb_master.put(2'h1, 1'h1, 16'h0583);
    // Look only once the edge that took the write has settled.
    #1;
    check("nostart", {15'h0000, o_busy}, 16'h0000);
    u_adcrb_master.put(2'h1, 1'h1, 16'h8583);
    u_adcrb_master.put(2'h1, 1'h1, 16'h85E3);
    #1;
    check("cfg", {1'h0, o_setup[14:0]}, 16'h05E3);
    idle();
    repeat (3) @(posedge i_clk);
    check("once", {15'h0000, o_busy}, 16'h0000);
  endtask
  task automatic t_regs;
    u_adcrb_master.put(2'h0, 1'h1, 16'h1234);
    u_adcrb_master.get(v);
    check("ro", v, 16'h8000);
    u_adcrb_master.put(2'h2, 1'h1, 16'hA5A5);
    u_adcrb_master.get(v);
    check("low", v, 16'hA5A5);
    u_adcrb_master.put(2'h3, 1'h1, 16'h5A5A);
    u_adcrb_master.get(v);
    check("high", v, 16'h5A5A);
  endtask
  // Continuous mode converts with no start writes; a read taken on the very edge that
  // loads a new result must still return the old word whole.
  task automatic t_cont;
    @(posedge i_clk);
    i_sample <= 20'h01234;
    u_adcrb_master.put(2'h1, 1'h1, 16'h8483);
    u_adcrb_master.put(2'h0, 1'h0, 16'h0000);
    repeat (`ADCRB_CONV_CYCLES - 4) @(posedge i_clk);
    u_adcrb_master.get(v);
    check("atomic", v, 16'h8000);
    u_adcrb_master.get(v);
    check("first", v, 16'h1234);
    @(posedge i_clk);
    i_sample <= 20'hFEDCB;
    repeat (2 * `ADCRB_CONV_CYCLES + 4) @(posedge i_clk);
    u_adcrb_master.get(v);
    check("continuous", v, 16'hEDCB);
    u_adcrb_master.put(2'h1, 1'h1, 16'h0583);
    idle();
    repeat (3) @(posedge i_clk);
    check("stopped", {15'h0000, o_busy}, 16'h0000);
  endtask
  initial begin
    i_reset_n = 1'h0;
    i_sample = 20'h00000;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'h1;
    t_reset();
    t_clip();
    t_busy();
    t_regs();
    t_cont();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    summarize();
  end
endmodule
bind adcrb_bank adcrb_bank_chk u_adcrb_bank_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_access(i_access),
  .o_busy(o_busy), .o_setup(o_setup), .o_low_limit(o_low_limit), .o_high_limit(o_high_limit));
